/* design/dpm_port_mux.sv */
// Purpose: three 16-bit pin ports, two strobe lines, peripheral output mux
// Assumes: classic wishbone slave, 100 MHz clk_i, pins asynchronous
// Notes:   pin_o and pin_oe_n_o are registered; oe_n low means driving
// Summary of operation
// - each pin: input, output, or peripheral
// - plain output drives drive-value register bit
// - sample register reads pin levels, read-only
// - direction bit: 0 input, 1 drive
// - mode bit: 0 plain, 1 peripheral
// - low select register: pins 7..0, 2 bits
// - high select register: pins 15..8, 2 bits
// - select field ignored while mode bit 0
// - codes 10/11 route buffer word bits
// - port 2 code 00: modulator phase pairs
// - port 2 code 01: timers, clocks, strobes
// - all control bits reset to zero
// - strobe levels read in bits 1:0
// - strobe direction bits 9:8, reset zero
// - strobe drive values from bits 5:4
`include "dpm_map.svh"

module dpm_port_mux #(
    parameter int NPORT = 3,           // number of 16-bit ports
    parameter int AW    = 8            // wishbone byte address width
) (
    input  wire logic                  clk_i,                 // system clock
    input  wire logic                  rst_i,                 // sync reset, high
    input  wire logic                  ce_i,                  // clock enable
    input  wire logic                  cyc_i,                 // wishbone cycle
    input  wire logic                  stb_i,                 // wishbone strobe
    input  wire logic                  we_i,                  // write enable
    input  wire logic [AW-1:0]         adr_i,                 // byte address
    input  wire logic [3:0]            sel_i,                 // byte lanes
    input  wire logic [31:0]           dat_i,                 // write data
    output logic      [31:0]           dat_o,                 // read data
    output logic                       ack_o,                 // transfer ack
    input  wire logic [NPORT*16-1:0]   pin_i,                 // pin levels
    output logic      [NPORT*16-1:0]   pin_o,                 // pin drive value
    output logic      [NPORT*16-1:0]   pin_oe_n_o,            // low = drive
    input  wire logic [1:0]            strobe_i,              // strobe levels
    output logic      [1:0]            strobe_o,              // strobe drive
    output logic      [1:0]            strobe_oe_n_o,         // low = drive
    input  wire dpm_pkg::dpm_word_t    first_buffer_word_i,   // buffer 0 out
    input  wire dpm_pkg::dpm_word_t    second_buffer_word_i,  // buffer 1 out
    input  wire logic [7:0]            first_modulator_phase_i,  // A+,A-..D-
    input  wire logic [7:0]            second_modulator_phase_i, // A+,A-..D-
    input  wire logic [5:0]            timer_channel_output_i,   // A0..B2
    input  wire logic [3:0]            programmable_clock_output_i // clk 0..3
);
    import dpm_pkg::*;

    // control registers, one word per port
    dpm_word_t          drive_q    [NPORT];     // port_drive_value
    dpm_word_t          dir_q      [NPORT];     // port_direction
    dpm_word_t          mode_q     [NPORT];     // port_source_mode
    dpm_word_t          sel_lo_q   [NPORT];     // port_periph_choice_low
    dpm_word_t          sel_hi_q   [NPORT];     // port_periph_choice_high
    logic [1:0]         str_drive_q;            // strobe drive values
    logic [1:0]         str_dir_q;              // strobe directions
    // synchronisers: first stage is read only by the second
    logic [NPORT*16-1:0] pin_m_q;               // pin meta stage
    logic [NPORT*16-1:0] pin_s_q;               // pin stable level
    logic [1:0]          str_m_q;               // strobe meta stage
    logic [1:0]          str_s_q;               // strobe stable level
    // bus decode
    logic               req;                    // new request this cycle
    logic [1:0]         a_port;                 // addressed port slot
    dpm_rix_t           a_rix;                  // addressed register
    logic               a_is_port;              // a real port slot
    logic               a_is_str;               // the strobe register
    logic [31:0]        rd_d;                   // read mux
    // peripheral candidate vectors per port
    dpm_word_t          alt0   [NPORT];         // code 00 sources
    dpm_word_t          alt1   [NPORT];         // code 01 sources
    logic [NPORT*16-1:0] pin_d;                 // next pin value
    logic [NPORT*16-1:0] oe_n_d;                // next pin enable

    // a request is taken once; ack is a single-cycle pulse
    assign req       = cyc_i && stb_i && !ack_o;
    assign a_port    = adr_i[`DPM_ADR_PORT_HI:`DPM_ADR_PORT_LO];
    assign a_rix     = adr_i[`DPM_ADR_REG_HI:`DPM_ADR_REG_LO];
    assign a_is_port = (32'(a_port) < NPORT);
    assign a_is_str  = (a_port == `DPM_STROBE_PORT) && (a_rix == `DPM_RIX_STROBE);

    // two-flop synchronisers for pins and strobes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_m_q <= '0;
            pin_s_q <= '0;
            str_m_q <= '0;
            str_s_q <= '0;
        end
        else if (ce_i)
        begin
            pin_m_q <= pin_i;
            pin_s_q <= pin_m_q;
            str_m_q <= strobe_i;
            str_s_q <= str_m_q;
        end
    end

    // wishbone acknowledge, one cycle after the request is seen
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            ack_o <= 1'b0;
        else if (ce_i)
            ack_o <= req;
    end

    // port register writes with byte lanes; sample register ignores writes
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            for (int p = 0; p < NPORT; p++)
            begin
                drive_q[p]  <= `DPM_REG_RESET;
                dir_q[p]    <= `DPM_REG_RESET;
                mode_q[p]   <= `DPM_REG_RESET;
                sel_lo_q[p] <= `DPM_REG_RESET;
                sel_hi_q[p] <= `DPM_REG_RESET;
            end
        end
        else if (ce_i && req && we_i && a_is_port)
        begin
            for (int p = 0; p < NPORT; p++)
            begin
                if (32'(a_port) == p)
                begin
                    for (int b = 0; b < 2; b++)
                    begin
                        if (sel_i[b])
                        begin
                            unique case (a_rix)
                                `DPM_RIX_DRIVE:  drive_q[p][b*8 +: 8]  <= dat_i[b*8 +: 8];
                                `DPM_RIX_DIR:    dir_q[p][b*8 +: 8]    <= dat_i[b*8 +: 8];
                                `DPM_RIX_MODE:   mode_q[p][b*8 +: 8]   <= dat_i[b*8 +: 8];
                                `DPM_RIX_SEL_LO: sel_lo_q[p][b*8 +: 8] <= dat_i[b*8 +: 8];
                                `DPM_RIX_SEL_HI: sel_hi_q[p][b*8 +: 8] <= dat_i[b*8 +: 8];
                                default: ;      // sample and holes: no effect
                            endcase
                        end
                    end
                end
            end
        end
    end

    // strobe register: only drive and direction bits store
    // the enable keeps its own inverted flop so the pin needs no gate after a register
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            str_drive_q   <= '0;
            str_dir_q     <= '0;
            strobe_oe_n_o <= '1;
        end
        else if (ce_i && req && we_i && a_is_str)
        begin
            if (sel_i[0])
                str_drive_q <= dat_i[`DPM_STR_DRIVE_LO +: 2];
            if (sel_i[1])
            begin
                str_dir_q     <= dat_i[`DPM_STR_DIR_LO +: 2];
                strobe_oe_n_o <= ~dat_i[`DPM_STR_DIR_LO +: 2];
            end
        end
    end

    // read mux; unmapped addresses read zero and still ack
    always_comb
    begin
        rd_d = 32'h0000_0000;
        if (a_is_port)
        begin
            for (int p = 0; p < NPORT; p++)
            begin
                if (32'(a_port) == p)
                begin
                    unique case (a_rix)
                        `DPM_RIX_DRIVE:  rd_d[15:0] = drive_q[p];
                        `DPM_RIX_SAMPLE: rd_d[15:0] = pin_s_q[p*16 +: 16];
                        `DPM_RIX_DIR:    rd_d[15:0] = dir_q[p];
                        `DPM_RIX_MODE:   rd_d[15:0] = mode_q[p];
                        `DPM_RIX_SEL_LO: rd_d[15:0] = sel_lo_q[p];
                        `DPM_RIX_SEL_HI: rd_d[15:0] = sel_hi_q[p];
                        default:         rd_d = 32'h0000_0000;
                    endcase
                end
            end
        end
        else if (a_is_str)
        begin
            // reserved bits stay zero
            rd_d[`DPM_STR_LEVEL_LO +: 2] = str_s_q;
            rd_d[`DPM_STR_DRIVE_LO +: 2] = str_drive_q;
            rd_d[`DPM_STR_DIR_LO +: 2]   = str_dir_q;
        end
    end

    // read data registered with the ack
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            dat_o <= 32'h0000_0000;
        else if (ce_i)
            dat_o <= req ? rd_d : 32'h0000_0000;
    end

    // per-port candidate vectors; only the pwm port has alt sources
    generate
        for (genvar p = 0; p < NPORT; p++)
        begin : g_alt
            if (p == `DPM_PWM_PORT)
            begin : g_pwm
                // phases in pin order A+,A-,B+,...; pins 0..1 have no code 01 source
                assign alt0[p] = {second_modulator_phase_i, first_modulator_phase_i};
                assign alt1[p] = {~str_s_q, str_s_q, programmable_clock_output_i,
                                  timer_channel_output_i, 2'b00};
            end
            else
            begin : g_plain
                assign alt0[p] = 16'h0000;
                assign alt1[p] = 16'h0000;
            end
        end
    endgenerate

    // per-pin source selection
    generate
        for (genvar i = 0; i < NPORT*16; i++)
        begin : g_pin
            localparam int P = i / 16;          // port of this pin
            localparam int N = i % 16;          // bit within the port
            dpm_code_t code;                    // this pin's select field
            if (N < `DPM_SEL_SPLIT)
            begin : g_lo
                assign code = sel_lo_q[P][2*N +: 2];
            end
            else
            begin : g_hi
                assign code = sel_hi_q[P][2*(N-`DPM_SEL_SPLIT) +: 2];
            end
            always_comb
            begin
                if (mode_q[P][N])
                begin
                    oe_n_d[i] = 1'b0;           // peripheral always drives
                    unique case (code)
                        `DPM_CODE_ALT0: pin_d[i] = alt0[P][N];
                        `DPM_CODE_ALT1: pin_d[i] = alt1[P][N];
                        `DPM_CODE_BUF0: pin_d[i] = first_buffer_word_i[N];
                        `DPM_CODE_BUF1: pin_d[i] = second_buffer_word_i[N];
                    endcase
                end
                else
                begin
                    // select field ignored in plain mode
                    oe_n_d[i] = !dir_q[P][N];
                    pin_d[i]  = drive_q[P][N];
                end
            end
        end
    endgenerate

    // pin outputs registered so every top output is a flop
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            pin_o      <= '0;
            pin_oe_n_o <= '1;                   // all inputs
        end
        else if (ce_i)
        begin
            pin_o      <= pin_d;
            pin_oe_n_o <= oe_n_d;
        end
    end

    // strobe drive value comes straight from its register flop
    assign strobe_o      = str_drive_q;

    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence wb_read_s;
        ce_i && req && !we_i;
    endsequence

    sequence ack_given_s;
        ce_i ##0 ack_o;
    endsequence

    reset_all_in_a: assert property (disable iff (1'b0)
        rst_i |=> (pin_oe_n_o == '1) && (strobe_oe_n_o == 2'b11))
        else $error("pins not released after reset");
    ack_pulse_a: assert property (ack_given_s |=> !ack_o)
        else $error("ack longer than one cycle");
    plain_drive_a: assert property (ce_i && !mode_q[0][0] |=> pin_o[0] == $past(drive_q[0][0]))
        else $error("plain output value wrong");
    plain_input_a: assert property (ce_i && !mode_q[1][5] && !dir_q[1][5] |=> pin_oe_n_o[21])
        else $error("input pin driven");
    buffer_route_a: assert property (ce_i && mode_q[1][3] && sel_lo_q[1][7:6] == `DPM_CODE_BUF0
        |=> !pin_oe_n_o[19] && pin_o[19] == $past(first_buffer_word_i[3]))
        else $error("buffer bit not routed");
    pwm_route_a: assert property (ce_i && mode_q[2][9] && sel_hi_q[2][3:2] == `DPM_CODE_ALT0
        |=> pin_o[41] == $past(second_modulator_phase_i[1]))
        else $error("modulator phase not routed");
    strobe_route_a: assert property (ce_i && mode_q[2][14] && sel_hi_q[2][13:12] == `DPM_CODE_ALT1
        |=> pin_o[46] == !$past(str_s_q[0]))
        else $error("inverted strobe not routed");
    unlisted_low_a: assert property (ce_i && mode_q[0][2] && !sel_lo_q[0][5]
        |=> !pin_o[2] && !pin_oe_n_o[2])
        else $error("unlisted code not driven low");
    strobe_read_a: assert property (wb_read_s ##0 a_is_str |=> dat_o[31:10] == '0
        && dat_o[3:2] == 2'b00 && dat_o[1:0] == $past(str_s_q))
        else $error("strobe register read wrong");
    sample_read_a: assert property (wb_read_s ##0 a_port == 2'h0 && a_rix == `DPM_RIX_SAMPLE
        |=> ack_o && dat_o == {16'h0000, $past(pin_s_q[15:0])})
        else $error("sample register read wrong");

    // routing spot checks, one pin per source kind and two for the second buffer word
    pwm_first_a: assert property (ce_i && mode_q[2][0] && sel_lo_q[2][1:0] == `DPM_CODE_ALT0
        |=> pin_o[32] == $past(first_modulator_phase_i[0]))
        else $error("first modulator phase not routed");

    timer_route_a: assert property (ce_i && mode_q[2][7] && sel_lo_q[2][15:14] == `DPM_CODE_ALT1
        |=> pin_o[39] == $past(timer_channel_output_i[5]))
        else $error("timer output not routed");

    clock_route_a: assert property (ce_i && mode_q[2][10] && sel_hi_q[2][5:4] == `DPM_CODE_ALT1
        |=> pin_o[42] == $past(programmable_clock_output_i[2]))
        else $error("programmable clock not routed");

    no_source_low_a: assert property (ce_i && mode_q[2][1] && sel_lo_q[2][3:2] == `DPM_CODE_ALT1
        |=> !pin_o[33] && !pin_oe_n_o[33])
        else $error("pin without source not driven low");

    low_field_a: assert property (ce_i && mode_q[1][0] && sel_lo_q[1][1:0] == `DPM_CODE_BUF1
        |=> pin_o[16] == $past(second_buffer_word_i[0]))
        else $error("low select field misplaced");

    high_field_a: assert property (ce_i && mode_q[1][15] && sel_hi_q[1][15:14] == `DPM_CODE_BUF0
        |=> pin_o[31] == $past(first_buffer_word_i[15]))
        else $error("high select field misplaced");

    buffer_two_a: assert property (ce_i && mode_q[0][12] && sel_hi_q[0][9:8] == `DPM_CODE_BUF1
        |=> pin_o[12] == $past(second_buffer_word_i[12]))
        else $error("second buffer bit not routed");

    // plain mode: direction governs, a stale select field has no say
    select_ignored_a: assert property (ce_i && !mode_q[0][7] && sel_lo_q[0][15:14] == `DPM_CODE_BUF1
        |=> pin_o[7] == $past(drive_q[0][7]) && pin_oe_n_o[7] == !$past(dir_q[0][7]))
        else $error("select field used in plain mode");

    plain_enable_a: assert property (ce_i && !mode_q[2][0] && dir_q[2][0] |=> !pin_oe_n_o[32])
        else $error("output pin not driven");

    periph_enable_a: assert property (ce_i && mode_q[0][15] |=> !pin_oe_n_o[15])
        else $error("peripheral pin not driven");

    // strobe register writes reach the strobe pins one edge later
    sequence strobe_write_s;
        ce_i && req && we_i && a_is_str;
    endsequence

    strobe_dir_a: assert property (strobe_write_s ##0 sel_i[1]
        |=> strobe_oe_n_o == ~$past(dat_i[`DPM_STR_DIR_LO +: 2]))
        else $error("strobe direction not applied");

    strobe_drive_a: assert property (strobe_write_s ##0 sel_i[0]
        |=> strobe_o == $past(dat_i[`DPM_STR_DRIVE_LO +: 2]))
        else $error("strobe drive value not applied");

    // bus answer: one ack per request, read data zero outside the ack cycle
    ack_follow_a: assert property (ce_i && req |=> ack_o)
        else $error("request not acknowledged");

    read_idle_a: assert property (!ack_o |-> dat_o == '0)
        else $error("read data outside ack");

endmodule : dpm_port_mux

/* design/dpm_map.svh */
// Purpose: address map, field positions and reset values of the port block
// Assumes: byte addresses on a 32-bit wishbone bus, one register per word
// Notes:   port p register r sits at (p << 5) | (r << 2); strobe register at 0x60
`ifndef DPM_MAP_SVH
`define DPM_MAP_SVH

`define DPM_ADR_PORT_HI   6          // port index bits of the byte address
`define DPM_ADR_PORT_LO   5
`define DPM_ADR_REG_HI    4          // register index bits within a port
`define DPM_ADR_REG_LO    2
`define DPM_STROBE_PORT   2'h3       // port slot 3 holds the strobe register
`define DPM_RIX_DRIVE     3'h0       // port_drive_value
`define DPM_RIX_SAMPLE    3'h1       // port_pin_sample
`define DPM_RIX_DIR       3'h2       // port_direction
`define DPM_RIX_MODE      3'h3       // port_source_mode
`define DPM_RIX_SEL_LO    3'h4       // port_periph_choice_low
`define DPM_RIX_SEL_HI    3'h5       // port_periph_choice_high
`define DPM_RIX_STROBE    3'h0       // strobe_line_control
`define DPM_REG_RESET     16'h0000   // every control register
`define DPM_STR_LEVEL_LO  0          // strobe level bits 1:0
`define DPM_STR_DRIVE_LO  4          // strobe drive bits 5:4
`define DPM_STR_DIR_LO    8          // strobe direction bits 9:8
`define DPM_CODE_ALT0     2'h0       // pwm phases on port 2
`define DPM_CODE_ALT1     2'h1       // timers, clocks, strobes on port 2
`define DPM_CODE_BUF0     2'h2       // first buffer word
`define DPM_CODE_BUF1     2'h3       // second buffer word
`define DPM_PWM_PORT      2          // only port carrying alt codes
`define DPM_SEL_SPLIT     8          // pins at and above use the high register

`endif

/* design/dpm_pkg.sv */
// Purpose: shared types of the port block
// Assumes: three 16-bit ports
// Notes:   constants live in dpm_map.svh
package dpm_pkg;
    typedef logic [15:0] dpm_word_t;   // one port or one register
    typedef logic [1:0]  dpm_code_t;   // peripheral select code
    typedef logic [2:0]  dpm_rix_t;    // register index within a port
endpackage : dpm_pkg

/* tb/dpm_board_model.sv */
// Purpose: board side of the three ports and the two strobe lines
// Assumes: attached equipment drives every line that the block leaves undriven
// Notes:   resolved levels feed straight back into the block's pin inputs
module dpm_board_model (
    input  wire logic [47:0] pin_o_i,    // block pin drive value
    input  wire logic [47:0] pin_oe_n_i, // low = block drives the pin
    input  wire logic [1:0]  str_o_i,    // block strobe drive value
    input  wire logic [1:0]  str_oe_n_i, // low = block drives the strobe
    input  wire logic [47:0] ext_pin_i,  // equipment pin levels
    input  wire logic [1:0]  ext_str_i,  // equipment strobe levels
    output logic      [47:0] pin_lvl_o,  // resolved pin levels
    output logic      [1:0]  str_lvl_o   // resolved strobe levels
);
    timeunit 1ns;
    timeprecision 1ps;

    // equipment backs off wherever the block drives, so no line is ever fought over
    always_comb
    begin
        for (int i = 0; i < 48; i++)
            pin_lvl_o[i] = pin_oe_n_i[i] ? ext_pin_i[i] : pin_o_i[i];
        for (int i = 0; i < 2; i++)
            str_lvl_o[i] = str_oe_n_i[i] ? ext_str_i[i] : str_o_i[i];
    end
endmodule : dpm_board_model

/* tb/tb.sv */
// Purpose: register-level bench of the port block with a board model on the pins
// Assumes: one 100 MHz clock, bus answers within 50 cycles
// Notes:   expected pin values come from a shadow copy of the written registers
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dpm_pkg::*;

    logic             clk_i = 1'b0;          // system clock
    logic             rst_i = 1'b1;          // sync reset, high
    logic             cyc   = 1'b0;          // bus cycle
    logic             stb   = 1'b0;          // bus strobe
    logic             we    = 1'b0;          // bus write
    logic [7:0]       adr   = 8'h00;         // byte address
    logic [31:0]      wdat  = 32'h0;         // write data
    logic [31:0]      rdat;                  // read data
    logic             ack;                   // bus ack
    logic [47:0]      pin_o, oe_n, pin_lvl;  // pin side
    logic [1:0]       str_o, str_oe_n, str_lvl; // strobe side
    logic [47:0]      ext_pin = {3{16'h3c96}}; // equipment pin levels
    logic [1:0]       ext_str = 2'h1;        // equipment strobe levels
    dpm_word_t        buf0 = 16'h1234;       // first buffer word
    dpm_word_t        buf1 = 16'habcd;       // second buffer word
    logic [7:0]       pwm0 = 8'h96;          // first modulator phases
    logic [7:0]       pwm1 = 8'h5a;          // second modulator phases
    logic [5:0]       tmr  = 6'h2d;          // timer outputs
    logic [3:0]       pclk = 4'h9;           // programmable clocks
    logic [15:0]      sh [3][6] = '{default: 16'h0}; // shadow of port registers
    logic [31:0]      q;                     // scratch read data
    int               bad_count = 0;         // mismatches
    int               n_checks  = 0;         // comparisons made
    // mode, select low, select high per row; last row mixes fields and plain pins
    logic [15:0]      tbl [5][3] = '{'{16'hffff, 16'h0000, 16'h0000}, '{16'hffff, 16'h5555, 16'h5555},
                                     '{16'hffff, 16'haaaa, 16'haaaa}, '{16'hffff, 16'hffff, 16'hffff},
                                     '{16'hf00f, 16'he002, 16'hb00b}};

    always #5 clk_i = ~clk_i;

    dpm_port_mux i_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we),
        .adr_i(adr), .sel_i(4'h3), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .pin_i(pin_lvl), .pin_o(pin_o),
        .pin_oe_n_o(oe_n), .strobe_i(str_lvl), .strobe_o(str_o), .strobe_oe_n_o(str_oe_n),
        .first_buffer_word_i(buf0), .second_buffer_word_i(buf1), .first_modulator_phase_i(pwm0),
        .second_modulator_phase_i(pwm1), .timer_channel_output_i(tmr), .programmable_clock_output_i(pclk));

    dpm_board_model i_board (.pin_o_i(pin_o), .pin_oe_n_i(oe_n), .str_o_i(str_o), .str_oe_n_i(str_oe_n),
        .ext_pin_i(ext_pin), .ext_str_i(ext_str), .pin_lvl_o(pin_lvl), .str_lvl_o(str_lvl));

    // report and stop; the only place the run ends
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // one comparison, four-state exact
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // classic single cycle; held until ack is seen high at a rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [31:0] rq);
        int k;
        @(posedge clk_i);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= {16'h0, d};
        k = 0;
        do
        begin
            @(posedge clk_i);
            k++;
        end
        while (ack !== 1'b1 && k < 50);
        rq = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (ack !== 1'b1)
        begin
            bad_count++;
            $display("[ERR] bus ack expected 1 seen %b", ack);
            give_verdict();
        end
    endtask : wb

    // register write that keeps the shadow in step
    task automatic wr(input int p, input int r, input logic [15:0] v);
        logic [31:0] rq;
        sh[p][r] = v;
        wb(1'b1, 8'(p * 32 + r * 4), v, rq);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [15:0] e, input string what);
        logic [31:0] rq;
        wb(1'b0, a, 16'h0, rq);
        chk(what, {16'h0, e}, rq);
    endtask : rd

    // peripheral source of pin n on port p, decoded from the shadow select fields
    function automatic logic src(input int p, input int n);
        logic [1:0] c;
        c = (n < 8) ? sh[p][4][2*n +: 2] : sh[p][5][2*(n-8) +: 2];
        case (c)
            2'h2:    return buf0[n];
            2'h3:    return buf1[n];
            2'h0:    return (p != 2) ? 1'b0 : (n < 8) ? pwm0[n] : pwm1[n-8];
            default: return (p != 2 || n < 2) ? 1'b0 : (n < 8) ? tmr[n-2] : (n < 12) ? pclk[n-8] :
                            (n < 14) ? str_lvl[n-12] : ~str_lvl[n-14];
        endcase
    endfunction : src

    // pins settle two edges after a write; only driven pins carry a value
    task automatic check_pins;
        logic [15:0] oe, ex;
        repeat (3) @(posedge clk_i);
        for (int p = 0; p < 3; p++)
        begin
            oe = sh[p][3] | sh[p][2];
            for (int n = 0; n < 16; n++)
                ex[n] = sh[p][3][n] ? src(p, n) : sh[p][0][n];
            chk("pin enable", {16'h0, ~oe}, {16'h0, oe_n[p*16 +: 16]});
            chk("pin value", {16'h0, ex & oe}, {16'h0, pin_o[p*16 +: 16] & oe});
        end
    endtask : check_pins

    task automatic check_reset;
        for (int p = 0; p < 3; p++)
            for (int r = 0; r < 6; r++)
                if (r != 1)
                    rd(8'(p * 32 + r * 4), 16'h0000, "reset value");
        check_pins();
        chk("strobe enable", 32'h3, {30'h0, str_oe_n});
        chk("strobe drive", 32'h0, {30'h0, str_o});
    endtask : check_reset

    // main sequence
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        check_reset();
        rd(8'h60, 16'h0001, "strobe levels");
        wb(1'b1, 8'h7c, 16'hffff, q);
        rd(8'h7c, 16'h0000, "unmapped read");
        for (int p = 0; p < 3; p++)
        begin
            wr(p, 0, 16'ha5c3 ^ 16'(p));
            wr(p, 2, 16'hff0f);
            rd(8'(p * 32), 16'ha5c3 ^ 16'(p), "drive readback");
        end
        check_pins();
        for (int p = 0; p < 3; p++)
        begin
            rd(8'(p * 32 + 4), ((16'ha5c3 ^ 16'(p)) & 16'hff0f) | (16'h3c96 & 16'h00f0), "sample");
            wb(1'b1, 8'(p * 32 + 4), 16'hffff, q);
            rd(8'(p * 32 + 4), ((16'ha5c3 ^ 16'(p)) & 16'hff0f) | (16'h3c96 & 16'h00f0), "sample");
        end
        wb(1'b1, 8'h60, 16'hffef, q);
        repeat (3) @(posedge clk_i);
        rd(8'h60, 16'h0322, "strobe register");
        chk("strobe enable", 32'h0, {30'h0, str_oe_n});
        chk("strobe drive", 32'h2, {30'h0, str_o});
        for (int t = 0; t < 5; t++)
        begin
            for (int p = 0; p < 3; p++)
            begin
                wr(p, 3, tbl[t][0]);
                wr(p, 4, tbl[t][1]);
                wr(p, 5, tbl[t][2]);
            end
            check_pins();
        end
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        sh = '{default: 16'h0};
        check_reset();
        repeat (3) @(posedge clk_i);
        rd(8'h60, 16'h0001, "strobe after reset");
        give_verdict();
    end
endmodule : tb
